/* File: hdl/pad_drive_input_config.sv */
// Functional notes
// - Sink-only bit set: pad pulls low only, releases line for high.
// - Sink-only bit clear: pad drives both high and low.
// - Port C and D sink-only registers: 8 RW bits, reset 0.
// - Port E sink-only register implements bits 2 to 0 only.
// - Slew bit set: slew limiting asserted toward the pad.
// - Slew bit clear: pad slews at maximum rate.
// - Port A to D slew registers: 8 RW bits, reset all ones.
// - Port E slew register implements bits 2 to 0 only.
// - Threshold bit set: Schmitt input feeds reads and change detection.
// - Threshold bit clear: TTL input feeds reads and change detection.
// - Port A to D threshold registers: 8 RW bits, reset all ones.
// - Port B pins 2,1 use Schmitt input when claimed by I2C.
// - Port C pins 4,3 use Schmitt input when claimed by I2C.
// - Port E threshold register: bits 3 to 0 RW, reset ones.
`timescale 1ns/1ns
`default_nettype none

module pad_drive_input_config
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial peripheral I2C claim.
   input wire logic i2c_mode_en,
   input wire logic i2c_on_port_b,
   input wire logic i2c_on_port_c,
   // Port output requests from the port logic.
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_out_en,
   input wire logic [7:0] port_b_out,
   input wire logic [7:0] port_b_out_en,
   input wire logic [7:0] port_c_out,
   input wire logic [7:0] port_c_out_en,
   input wire logic [7:0] port_d_out,
   input wire logic [7:0] port_d_out_en,
   input wire logic [2:0] port_e_out,
   input wire logic [2:0] port_e_out_en,
   // Pad input buffers.
   input wire logic [7:0] pad_a_st,
   input wire logic [7:0] pad_a_ttl,
   input wire logic [7:0] pad_b_st,
   input wire logic [7:0] pad_b_ttl,
   input wire logic [7:0] pad_c_st,
   input wire logic [7:0] pad_c_ttl,
   input wire logic [7:0] pad_d_st,
   input wire logic [7:0] pad_d_ttl,
   input wire logic [3:0] pad_e_st,
   input wire logic [3:0] pad_e_ttl,
   // Pad drivers.
   output logic [7:0] pad_a_out,
   output logic [7:0] pad_a_oe,
   output logic [7:0] pad_a_slew,
   output logic [7:0] pad_b_out,
   output logic [7:0] pad_b_oe,
   output logic [7:0] pad_b_slew,
   output logic [7:0] pad_c_out,
   output logic [7:0] pad_c_oe,
   output logic [7:0] pad_c_slew,
   output logic [7:0] pad_d_out,
   output logic [7:0] pad_d_oe,
   output logic [7:0] pad_d_slew,
   output logic [2:0] pad_e_out,
   output logic [2:0] pad_e_oe,
   output logic [2:0] pad_e_slew,
   // Selected input levels for port reads and change detection.
   output logic [7:0] pin_a_level,
   output logic [7:0] pin_b_level,
   output logic [7:0] pin_c_level,
   output logic [7:0] pin_d_level,
   output logic [3:0] pin_e_level
);

   // ----------------------------------------------------------------
   // Register storage and bus decode.
   // ----------------------------------------------------------------
   logic [7:0] regs_q [13];
   logic [12:0] hit;
   logic any_hit;
   logic access;
   logic wr_en;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [7:0] rd_d;

   // ----------------------------------------------------------------
   // Access phase detection.
   // ----------------------------------------------------------------
   assign access = psel & penable & ~pready_q;

   // ----------------------------------------------------------------
   // Write enable in the completing access cycle.
   // ----------------------------------------------------------------
   assign wr_en = psel & penable & pready_q & pwrite & pstrb[0];

   // ----------------------------------------------------------------
   // Decode and storage per register.
   // ----------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < 13; k++)
      begin : g_reg
         assign hit[k] = (paddr[13:2] == pad_cfg_pkg::reg_index[k]);
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               regs_q[k] <= pad_cfg_pkg::reg_reset[k]
                            & pad_cfg_pkg::reg_mask[k];
            else if (wr_en && hit[k])
               regs_q[k] <= pwdata[7:0]
                            & pad_cfg_pkg::reg_mask[k];
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read selection.
   // ----------------------------------------------------------------
   assign any_hit = |hit;

   always_comb
   begin
      rd_d = 8'h00;
      unique case (paddr[13:2])
         pad_cfg_pkg::idx_port_a_input_threshold:
            rd_d = regs_q[pad_cfg_pkg::slot_thr_a];
         pad_cfg_pkg::idx_port_a_slew_limit:
            rd_d = regs_q[pad_cfg_pkg::slot_slew_a];
         pad_cfg_pkg::idx_port_b_input_threshold:
            rd_d = regs_q[pad_cfg_pkg::slot_thr_b];
         pad_cfg_pkg::idx_port_b_slew_limit:
            rd_d = regs_q[pad_cfg_pkg::slot_slew_b];
         pad_cfg_pkg::idx_port_c_input_threshold:
            rd_d = regs_q[pad_cfg_pkg::slot_thr_c];
         pad_cfg_pkg::idx_port_c_slew_limit:
            rd_d = regs_q[pad_cfg_pkg::slot_slew_c];
         pad_cfg_pkg::idx_port_c_sink_only_drive:
            rd_d = regs_q[pad_cfg_pkg::slot_sink_c];
         pad_cfg_pkg::idx_port_d_input_threshold:
            rd_d = regs_q[pad_cfg_pkg::slot_thr_d];
         pad_cfg_pkg::idx_port_d_slew_limit:
            rd_d = regs_q[pad_cfg_pkg::slot_slew_d];
         pad_cfg_pkg::idx_port_d_sink_only_drive:
            rd_d = regs_q[pad_cfg_pkg::slot_sink_d];
         pad_cfg_pkg::idx_port_e_input_threshold:
            rd_d = regs_q[pad_cfg_pkg::slot_thr_e];
         pad_cfg_pkg::idx_port_e_slew_limit:
            rd_d = regs_q[pad_cfg_pkg::slot_slew_e];
         pad_cfg_pkg::idx_port_e_sink_only_drive:
            rd_d = regs_q[pad_cfg_pkg::slot_sink_e];
         default:
            rd_d = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // APB answer: one wait state, error on an unmapped address.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready_q <= 1'b0;
      else
         pready_q <= access;
   end

   // ----------------------------------------------------------------
   // Error answer for an unmapped address.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr_q <= 1'b0;
      else
         pslverr_q <= access & ~any_hit;
   end

   // ----------------------------------------------------------------
   // Read data, standing only while ready is high.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= 32'h0000_0000;
      else if (access && !pwrite)
         prdata_q <= {24'h00_0000, rd_d};
      else if (pready_q)
         prdata_q <= 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // Bus answer outputs.
   // ----------------------------------------------------------------
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   // ----------------------------------------------------------------
   // Per-pin pad control over all forty pin positions.
   // ----------------------------------------------------------------
   // Requests and pad inputs gathered over all pins.
   logic [39:0] req_out;
   logic [39:0] req_en;
   logic [39:0] in_st;
   logic [39:0] in_ttl;

   // Register fields spread over all pins.
   logic [39:0] sink_only;
   logic [39:0] slew_lim;
   logic [39:0] thr_st;
   logic [39:0] force_st;
   logic claim_b;
   logic claim_c;

   // Next values.
   logic [39:0] out_d;
   logic [39:0] oe_d;
   logic [39:0] level_d;

   // Registered pad controls.
   logic [39:0] out_q;
   logic [39:0] oe_q;
   logic [39:0] slew_q;
   logic [39:0] level_q;

   // ----------------------------------------------------------------
   // Requests and pad inputs gathered over all pins.
   // ----------------------------------------------------------------
   assign req_out = {5'h00, port_e_out, port_d_out, port_c_out,
                     port_b_out, port_a_out};
   assign req_en = {5'h00, port_e_out_en, port_d_out_en, port_c_out_en,
                    port_b_out_en, port_a_out_en};
   assign in_st = {4'h0, pad_e_st, pad_d_st, pad_c_st, pad_b_st, pad_a_st};
   assign in_ttl = {4'h0, pad_e_ttl, pad_d_ttl, pad_c_ttl, pad_b_ttl,
                    pad_a_ttl};

   // ----------------------------------------------------------------
   // Register fields spread over all pins.
   // ----------------------------------------------------------------
   assign sink_only = {regs_q[pad_cfg_pkg::slot_sink_e],
                       regs_q[pad_cfg_pkg::slot_sink_d],
                       regs_q[pad_cfg_pkg::slot_sink_c], 16'h0000};
   assign slew_lim = {regs_q[pad_cfg_pkg::slot_slew_e],
                      regs_q[pad_cfg_pkg::slot_slew_d],
                      regs_q[pad_cfg_pkg::slot_slew_c],
                      regs_q[pad_cfg_pkg::slot_slew_b],
                      regs_q[pad_cfg_pkg::slot_slew_a]};

   // ----------------------------------------------------------------
   // Input threshold choice per pin.
   // ----------------------------------------------------------------
   assign thr_st = {regs_q[pad_cfg_pkg::slot_thr_e],
                    regs_q[pad_cfg_pkg::slot_thr_d],
                    regs_q[pad_cfg_pkg::slot_thr_c],
                    regs_q[pad_cfg_pkg::slot_thr_b],
                    regs_q[pad_cfg_pkg::slot_thr_a]};

   // ----------------------------------------------------------------
   // An I2C claim forces the Schmitt input on the claimed pins.
   // ----------------------------------------------------------------
   assign claim_b = i2c_mode_en & i2c_on_port_b;
   assign claim_c = i2c_mode_en & i2c_on_port_c;
   assign force_st = {16'h0000,
      pad_cfg_pkg::i2c_pins_c & {8{claim_c}},
      pad_cfg_pkg::i2c_pins_b & {8{claim_b}},
      8'h00};

   // ----------------------------------------------------------------
   // Per-pin drive and input selection.
   // ----------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < 40; p++)
      begin : g_pin
         // A sink-only pin drives zero and releases when high is wanted.
         assign out_d[p] = req_out[p] & ~sink_only[p];
         assign oe_d[p] = req_en[p] & (~sink_only[p] | ~req_out[p]);
         assign level_d[p] = (thr_st[p] | force_st[p]) ? in_st[p]
                                                        : in_ttl[p];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Drive value register.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         out_q <= 40'h00_0000_0000;
      else
         out_q <= out_d;
   end

   // ----------------------------------------------------------------
   // Drive enable register.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         oe_q <= 40'h00_0000_0000;
      else
         oe_q <= oe_d;
   end

   // ----------------------------------------------------------------
   // Slew limit register.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         slew_q <= {pad_cfg_pkg::reg_reset[pad_cfg_pkg::slot_slew_e],
                    32'hffff_ffff};
      else
         slew_q <= slew_lim;
   end

   // ----------------------------------------------------------------
   // Selected input level register.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         level_q <= 40'h00_0000_0000;
      else
         level_q <= level_d;
   end

   // ----------------------------------------------------------------
   // Drive value slices.
   // ----------------------------------------------------------------
   assign pad_a_out = out_q[7:0];
   assign pad_b_out = out_q[15:8];
   assign pad_c_out = out_q[23:16];
   assign pad_d_out = out_q[31:24];
   assign pad_e_out = out_q[34:32];

   // ----------------------------------------------------------------
   // Drive enable slices.
   // ----------------------------------------------------------------
   assign pad_a_oe = oe_q[7:0];
   assign pad_b_oe = oe_q[15:8];
   assign pad_c_oe = oe_q[23:16];
   assign pad_d_oe = oe_q[31:24];
   assign pad_e_oe = oe_q[34:32];

   // ----------------------------------------------------------------
   // Slew limit slices.
   // ----------------------------------------------------------------
   assign pad_a_slew = slew_q[7:0];
   assign pad_b_slew = slew_q[15:8];
   assign pad_c_slew = slew_q[23:16];
   assign pad_d_slew = slew_q[31:24];
   assign pad_e_slew = slew_q[34:32];

   // ----------------------------------------------------------------
   // Selected input level slices.
   // ----------------------------------------------------------------
   assign pin_a_level = level_q[7:0];
   assign pin_b_level = level_q[15:8];
   assign pin_c_level = level_q[23:16];
   assign pin_d_level = level_q[31:24];
   assign pin_e_level = level_q[35:32];

endmodule

`default_nettype wire

/* File: inc/pad_cfg_pkg.sv */
package pad_cfg_pkg;

   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ----------------------------------------------------------------
   localparam int unsigned num_regs = 13;
   localparam logic [11:0] idx_port_a_input_threshold = 12'hf0d;
   localparam logic [11:0] idx_port_a_slew_limit = 12'hf0e;
   localparam logic [11:0] idx_port_b_input_threshold = 12'hf15;
   localparam logic [11:0] idx_port_b_slew_limit = 12'hf16;
   localparam logic [11:0] idx_port_c_input_threshold = 12'hf1d;
   localparam logic [11:0] idx_port_c_slew_limit = 12'hf1e;
   localparam logic [11:0] idx_port_c_sink_only_drive = 12'hf1f;
   localparam logic [11:0] idx_port_d_input_threshold = 12'hf22;
   localparam logic [11:0] idx_port_d_slew_limit = 12'hf23;
   localparam logic [11:0] idx_port_d_sink_only_drive = 12'hf24;
   localparam logic [11:0] idx_port_e_input_threshold = 12'hf2a;
   localparam logic [11:0] idx_port_e_slew_limit = 12'hf2b;
   localparam logic [11:0] idx_port_e_sink_only_drive = 12'hf2c;

   // ----------------------------------------------------------------
   // Slot numbers of the registers in the storage array.
   // ----------------------------------------------------------------
   localparam int unsigned slot_thr_a = 0;
   localparam int unsigned slot_slew_a = 1;
   localparam int unsigned slot_thr_b = 2;
   localparam int unsigned slot_slew_b = 3;
   localparam int unsigned slot_thr_c = 4;
   localparam int unsigned slot_slew_c = 5;
   localparam int unsigned slot_sink_c = 6;
   localparam int unsigned slot_thr_d = 7;
   localparam int unsigned slot_slew_d = 8;
   localparam int unsigned slot_sink_d = 9;
   localparam int unsigned slot_thr_e = 10;
   localparam int unsigned slot_slew_e = 11;
   localparam int unsigned slot_sink_e = 12;

   localparam logic [12:0][11:0] reg_index = {
      idx_port_e_sink_only_drive, idx_port_e_slew_limit,
      idx_port_e_input_threshold, idx_port_d_sink_only_drive,
      idx_port_d_slew_limit, idx_port_d_input_threshold,
      idx_port_c_sink_only_drive, idx_port_c_slew_limit,
      idx_port_c_input_threshold, idx_port_b_slew_limit,
      idx_port_b_input_threshold, idx_port_a_slew_limit,
      idx_port_a_input_threshold};

   // ----------------------------------------------------------------
   // Implemented bits and reset values.
   // ----------------------------------------------------------------
   localparam logic [7:0] mask_full = 8'hff;
   localparam logic [7:0] mask_e_thr = 8'h0f;
   localparam logic [7:0] mask_e_drive = 8'h07;
   localparam logic [7:0] reset_thr = 8'hff;
   localparam logic [7:0] reset_slew = 8'hff;
   localparam logic [7:0] reset_sink = 8'h00;

   localparam logic [12:0][7:0] reg_mask = {
      mask_e_drive, mask_e_drive, mask_e_thr, mask_full, mask_full,
      mask_full, mask_full, mask_full, mask_full, mask_full, mask_full,
      mask_full, mask_full};

   localparam logic [12:0][7:0] reg_reset = {
      reset_sink, reset_slew, reset_thr, reset_sink, reset_slew,
      reset_thr, reset_sink, reset_slew, reset_thr, reset_slew,
      reset_thr, reset_slew, reset_thr};

   // ----------------------------------------------------------------
   // Pin positions that the serial peripheral may claim for I2C.
   // ----------------------------------------------------------------
   localparam logic [7:0] i2c_pins_b = 8'h06;
   localparam logic [7:0] i2c_pins_c = 8'h18;

endpackage

/* File: testbench/pad_cfg_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module pad_cfg_chk
(
   // Bus.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pads.
   input wire logic i2c_mode_en,
   input wire logic i2c_on_port_b,
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_out_en,
   input wire logic [7:0] port_c_out,
   input wire logic [7:0] port_c_out_en,
   input wire logic [7:0] pad_a_st,
   input wire logic [7:0] pad_a_ttl,
   input wire logic [7:0] pad_b_st,
   input wire logic [7:0] pad_a_out,
   input wire logic [7:0] pad_a_oe,
   input wire logic [7:0] pad_c_out,
   input wire logic [7:0] pad_c_oe,
   input wire logic [7:0] pin_a_level,
   input wire logic [7:0] pin_b_level
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----
   // Checks.
   // ----
   chk_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("ready late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready too long");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   chk_a_push_pull: assert property ($past(presetn) |->
      pad_a_out == $past(port_a_out) && pad_a_oe == $past(port_a_out_en))
      else $error("port a drive wrong");
   chk_c_sink_only: assert property ($past(presetn) |->
      (pad_c_oe & ~$past(port_c_out_en)) == 8'h0 &&
      (pad_c_out & ~$past(port_c_out)) == 8'h0)
      else $error("port c drive wrong");
   chk_a_level: assert property ($past(presetn) |->
      ((pin_a_level ^ $past(pad_a_st)) &
      (pin_a_level ^ $past(pad_a_ttl))) == 8'h0)
      else $error("port a level from no buffer");
   chk_b_i2c: assert property ($past(presetn) &&
      $past(i2c_mode_en) && $past(i2c_on_port_b) |->
      (pin_b_level & 8'h06) == ($past(pad_b_st) & 8'h06))
      else $error("port b i2c level wrong");
endmodule
bind pad_drive_input_config pad_cfg_chk chk_i (.*);
`default_nettype wire

/* File: testbench/pad_far_side.sv */
`timescale 1ns/1ns
`default_nettype none
module pad_far_side
(
   // Pad drivers.
   input wire logic [35:0] out,
   input wire logic [35:0] oe,
   // Outside world level and middling pins.
   input wire logic [35:0] ext,
   input wire logic [35:0] mid,
   // Input buffers.
   output logic [35:0] st,
   output logic [35:0] ttl
);
   // ----
   // Pin level.
   // ----
   logic [35:0] lvl;
   // A released pin shows what the outside world puts on it.
   assign lvl = (oe & out) | (~oe & ext);
   // A middling level reads high through TTL but low through Schmitt.
   assign st = lvl & ~mid;
   assign ttl = lvl | mid;
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, pad_e_st, pad_e_ttl, pin_e_level;
   logic i2c_mode_en, i2c_on_port_b, i2c_on_port_c;
   logic [7:0] port_a_out, port_a_out_en, port_b_out, port_b_out_en;
   logic [7:0] port_c_out, port_c_out_en, port_d_out, port_d_out_en;
   logic [2:0] port_e_out, port_e_out_en, pad_e_out, pad_e_oe, pad_e_slew;
   logic [7:0] pad_a_st, pad_a_ttl, pad_b_st, pad_b_ttl, pad_c_st;
   logic [7:0] pad_c_ttl, pad_d_st, pad_d_ttl, pad_a_out, pad_a_oe;
   logic [7:0] pad_a_slew, pad_b_out, pad_b_oe, pad_b_slew, pad_c_out;
   logic [7:0] pad_c_oe, pad_c_slew, pad_d_out, pad_d_oe, pad_d_slew;
   logic [7:0] pin_a_level, pin_b_level, pin_c_level, pin_d_level;
   logic [35:0] ext, mid;
   logic [7:0] m [13];
   logic [32:0] q [$];
   int fails, cmp_count;
   pad_drive_input_config DUT (.*);
   pad_far_side far_i (
      .out({1'b0, pad_e_out, pad_d_out, pad_c_out, pad_b_out, pad_a_out}),
      .oe({1'b0, pad_e_oe, pad_d_oe, pad_c_oe, pad_b_oe, pad_a_oe}),
      .ext(ext),
      .mid(mid),
      .st({pad_e_st, pad_d_st, pad_c_st, pad_b_st, pad_a_st}),
      .ttl({pad_e_ttl, pad_d_ttl, pad_c_ttl, pad_b_ttl, pad_a_ttl})
   );
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // ----
   // Tasks.
   // ----
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic xfer(input logic wr, input logic [11:0] idx,
      input logic [31:0] d, input logic [3:0] stb, input logic [32:0] exp);
      int n;
      q.push_back(exp);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      pstrb <= stb;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         fails++;
         end_of_test();
      end
   endtask
   function automatic logic [7:0] pick(input logic [7:0] s, a, b);
      return (s & a) | (~s & b);
   endfunction
   always @(posedge pclk)
      if (pready === 1'b1)
         check({pslverr, prdata}, q.pop_front());
   // ----
   // Main sequence.
   // ----
   initial
   begin
      logic [31:0] d;
      logic [7:0] ob;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {port_a_out, port_a_out_en, port_b_out, port_b_out_en} = '0;
      {port_c_out, port_c_out_en, port_d_out, port_d_out_en} = '0;
      {port_e_out, port_e_out_en, ext, mid} = '0;
      {i2c_mode_en, i2c_on_port_b, i2c_on_port_c} = 3'h0;
      presetn = 1'b0;
      fails = 0;
      cmp_count = 0;
      void'($urandom(32'hca336ba3));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 13; i++)
         xfer(1'b0, pad_cfg_pkg::reg_index[i], $urandom, 4'hf,
            {25'h0, pad_cfg_pkg::reg_reset[i] & pad_cfg_pkg::reg_mask[i]});
      $display("test reset values done");
      for (int i = 0; i < 13; i++)
      begin
         d = $urandom;
         m[i] = d[7:0] & pad_cfg_pkg::reg_mask[i];
         xfer(1'b1, pad_cfg_pkg::reg_index[i], d, 4'hf, 33'h0);
      end
      xfer(1'b1, pad_cfg_pkg::reg_index[0], ~d, 4'he, 33'h0);
      xfer(1'b1, 12'hf0f, d, 4'hf, 33'h100000000);
      xfer(1'b0, 12'hf0f, d, 4'hf, 33'h100000000);
      for (int i = 0; i < 13; i++)
         xfer(1'b0, pad_cfg_pkg::reg_index[i], d, 4'hf, {25'h0, m[i]});
      $display("test read back done");
      xfer(1'b1, pad_cfg_pkg::idx_port_c_sink_only_drive, 32'hf0, 4'hf, '0);
      xfer(1'b1, pad_cfg_pkg::idx_port_c_slew_limit, 32'h5a, 4'hf, '0);
      xfer(1'b1, pad_cfg_pkg::idx_port_a_input_threshold, 32'h0f, 4'hf, '0);
      xfer(1'b1, pad_cfg_pkg::idx_port_b_input_threshold, 32'h00, 4'hf, '0);
      psel <= 1'b0;
      penable <= 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         {port_a_out, port_a_out_en, port_c_out, port_c_out_en} <= $urandom;
         {port_b_out, port_b_out_en, port_d_out, port_d_out_en} <= $urandom;
         {port_e_out, port_e_out_en} <= 6'($urandom);
         ext <= 36'({$urandom, $urandom});
         mid <= 36'({$urandom, $urandom});
         {i2c_mode_en, i2c_on_port_b, i2c_on_port_c} <= 3'(k);
         repeat (3) @(posedge pclk);
         ob = (k == 6 || k == 7) ? pad_cfg_pkg::i2c_pins_b : 8'h0;
         check(pad_a_out, port_a_out);
         check(pad_a_oe, port_a_out_en);
         check(pad_b_out, port_b_out);
         check(pad_b_oe, port_b_out_en);
         check(pad_d_out, port_d_out & ~m[9]);
         check(pad_d_oe, port_d_out_en & ~(port_d_out & m[9]));
         check(pad_e_oe, port_e_out_en & ~(port_e_out & m[12][2:0]));
         check(pad_a_slew, m[1]);
         check(pad_b_slew, m[3]);
         check(pad_d_slew, m[8]);
         check(pin_d_level, pick(m[7], pad_d_st, pad_d_ttl));
         check(pin_e_level, pick(m[10], 8'(pad_e_st), 8'(pad_e_ttl)));
         check(pad_c_out, port_c_out & 8'h0f);
         check(pad_c_oe, port_c_out_en & ~(port_c_out & 8'hf0));
         check(pad_e_out, port_e_out & ~m[12][2:0]);
         check(pad_c_slew, 8'h5a);
         check(pad_e_slew, m[11][2:0]);
         check(pin_a_level, pick(8'h0f, pad_a_st, pad_a_ttl));
         check(pin_b_level, pick(ob, pad_b_st, pad_b_ttl));
         ob = (k == 5 || k == 7) ? pad_cfg_pkg::i2c_pins_c : 8'h0;
         check(pin_c_level, pick(m[4] | ob, pad_c_st, pad_c_ttl));
      end
      $display("test pads done");
      end_of_test();
   end
endmodule
`default_nettype wire
